// ---- core/gsb_pkg.sv ----
// Package with address map, field layout and codes of the grouped status bus reporter
package gsb_pkg;
  // ****************************************
  // Register addresses
  // ****************************************
  localparam logic [7:0] GSB_ADDR_ENABLE_LINE = 8'hb0;
  localparam logic [7:0] GSB_ADDR_LINE_ALARM  = 8'hb1;
  localparam logic [7:0] GSB_ADDR_INT_STATUS  = 8'hb2;
  localparam logic [7:0] GSB_ADDR_SYNC_STATUS = 8'hb3;
  localparam logic [7:0] GSB_ADDR_USER_ONE    = 8'hb4;
  localparam logic [7:0] GSB_ADDR_USER_TWO    = 8'hb5;

  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int         GSB_ENABLE_BIT    = 0;
  localparam int         GSB_LINE_SEL_LSB  = 1;
  localparam int         GSB_ALARM_ONE_LSB = 0;
  localparam int         GSB_ALARM_TWO_LSB = 4;
  localparam logic [7:0] GSB_CTRL_RESET    = 8'h00;

  // ****************************************
  // Alarm selector codes
  // ****************************************
  typedef enum logic [2:0] {
    GSB_SEL_BLUE_OR_ALL_ONES = 3'h0,
    GSB_SEL_YELLOW_OR_REMOTE = 3'h1,
    GSB_SEL_LOOP_UP_OR_DMA   = 3'h2,
    GSB_SEL_LOOP_DN_OR_V5    = 3'h3,
    GSB_SEL_SIG_CHANGE       = 3'h4,
    GSB_SEL_ES_SLIP          = 3'h5
  } gsb_alarm_sel_t;

  // ****************************************
  // Group line codes, one per information address
  // ****************************************
  typedef enum logic [1:0] {
    GSB_GRP_INT   = 2'h0,
    GSB_GRP_SYNC  = 2'h1,
    GSB_GRP_USER1 = 2'h2,
    GSB_GRP_USER2 = 2'h3
  } gsb_grp_code_t;
endpackage

// ---- core/gsb_alarm_mux.sv ----
// Alarm source selector for one user status address
module gsb_alarm_mux
  import gsb_pkg::*;
(
  // Selection
  input  wire logic [2:0] sel,
  input  wire logic       e1_mode,
  // T1 sources
  input  wire logic       receive_blue_alarm,
  input  wire logic       receive_yellow_alarm,
  input  wire logic       loop_up_code_seen,
  input  wire logic       loop_down_code_seen,
  // E1 sources
  input  wire logic       receive_unframed_all_ones,
  input  wire logic       receive_remote_alarm,
  input  wire logic       distant_multiframe_alarm,
  input  wire logic       v5_link_indication,
  // Shared sources
  input  wire logic       signaling_change,
  input  wire logic       elastic_store_slip,
  // Result
  output logic            status
);
  always_comb begin
    case (sel)
      GSB_SEL_BLUE_OR_ALL_ONES: status = e1_mode ? receive_unframed_all_ones
                                                 : receive_blue_alarm;
      GSB_SEL_YELLOW_OR_REMOTE: status = e1_mode ? receive_remote_alarm
                                                 : receive_yellow_alarm;
      GSB_SEL_LOOP_UP_OR_DMA:   status = e1_mode ? distant_multiframe_alarm
                                                 : loop_up_code_seen;
      GSB_SEL_LOOP_DN_OR_V5:    status = e1_mode ? v5_link_indication
                                                 : loop_down_code_seen;
      GSB_SEL_SIG_CHANGE:       status = signaling_change;
      GSB_SEL_ES_SLIP:          status = elastic_store_slip;
      // Codes 6 and 7 carry no status, report clear
      default:                  status = 1'b0;
    endcase
  end
endmodule

// ---- core/gsb_reporter.sv ----
// Grouped status bus reporter: control registers, group line handshake, bus line drive
module gsb_reporter
  import gsb_pkg::*;
#(
  parameter int DATA_W = 8
)
(
  // Clock and reset
  input  wire logic              CLK,
  input  wire logic              RSTN,
  // Host parallel port
  input  wire logic [7:0]        ADDR,
  input  wire logic [DATA_W-1:0] WDATA,
  input  wire logic              WR,
  input  wire logic              RD,
  output logic      [DATA_W-1:0] AD_OUT,
  output logic      [DATA_W-1:0] AD_OE,
  // Group lines, open drain
  input  wire logic              GROUP_SELECT_A_IN,
  output logic                   GROUP_SELECT_A_OUT,
  output logic                   GROUP_SELECT_A_OE,
  input  wire logic              GROUP_SELECT_B_IN,
  output logic                   GROUP_SELECT_B_OUT,
  output logic                   GROUP_SELECT_B_OE,
  input  wire logic              GROUP_READ_IN,
  output logic                   GROUP_READ_OUT,
  output logic                   GROUP_READ_OE,
  // Device status
  input  wire logic              E1_MODE,
  input  wire logic              INTERRUPT_PENDING,
  input  wire logic              RX_SYNC_LOSS,
  input  wire logic              RX_BLUE_ALARM,
  input  wire logic              RX_YELLOW_ALARM,
  input  wire logic              LOOP_UP_SEEN,
  input  wire logic              LOOP_DOWN_SEEN,
  input  wire logic              SIGNALING_CHANGE,
  input  wire logic              ELASTIC_STORE_SLIP,
  input  wire logic              RX_UNFRAMED_ALL_ONES,
  input  wire logic              RX_REMOTE_ALARM,
  input  wire logic              DISTANT_MF_ALARM,
  input  wire logic              V5_LINK_INDICATION
);
  // ****************************************
  // Elaboration check
  // ****************************************
  // Line select is 3 bits, so the bus must be exactly eight lines
  if (DATA_W != 8) begin : g_bad_width
    $error("gsb_reporter supports only an 8-bit host bus");
  end

  // ****************************************
  // Control registers
  // ****************************************
  logic [7:0] enable_line_ff;
  logic [7:0] line_alarm_ff;
  logic       group_report_enable;
  logic [2:0] data_line_select;
  logic [2:0] alarm_select_one;
  logic [2:0] alarm_select_two;
  logic       wr_enable_line;
  logic       wr_line_alarm;

  assign group_report_enable = enable_line_ff[GSB_ENABLE_BIT];
  assign data_line_select    = enable_line_ff[GSB_LINE_SEL_LSB +: 3];
  assign alarm_select_one    = line_alarm_ff[GSB_ALARM_ONE_LSB +: 3];
  assign alarm_select_two    = line_alarm_ff[GSB_ALARM_TWO_LSB +: 3];
  assign wr_enable_line      = WR && (ADDR == GSB_ADDR_ENABLE_LINE);
  assign wr_line_alarm       = WR && (ADDR == GSB_ADDR_LINE_ALARM);

  // Only defined bits are stored, unused bits read back as zero
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      enable_line_ff <= GSB_CTRL_RESET;
      line_alarm_ff  <= GSB_CTRL_RESET;
    end else begin
      if (wr_enable_line) begin
        enable_line_ff <= {4'h0, WDATA[3:0]};
      end
      if (wr_line_alarm) begin
        line_alarm_ff <= {1'b0, WDATA[6:4], 1'b0, WDATA[2:0]};
      end
    end
  end

  // ****************************************
  // Alarm selection
  // ****************************************
  logic user_status_a;
  logic user_status_b;

  gsb_alarm_mux u_mux_one (
    .sel                       (alarm_select_one),
    .e1_mode                   (E1_MODE),
    .receive_blue_alarm        (RX_BLUE_ALARM),
    .receive_yellow_alarm      (RX_YELLOW_ALARM),
    .loop_up_code_seen         (LOOP_UP_SEEN),
    .loop_down_code_seen       (LOOP_DOWN_SEEN),
    .receive_unframed_all_ones (RX_UNFRAMED_ALL_ONES),
    .receive_remote_alarm      (RX_REMOTE_ALARM),
    .distant_multiframe_alarm  (DISTANT_MF_ALARM),
    .v5_link_indication        (V5_LINK_INDICATION),
    .signaling_change          (SIGNALING_CHANGE),
    .elastic_store_slip        (ELASTIC_STORE_SLIP),
    .status                    (user_status_a)
  );

  gsb_alarm_mux u_mux_two (
    .sel                       (alarm_select_two),
    .e1_mode                   (E1_MODE),
    .receive_blue_alarm        (RX_BLUE_ALARM),
    .receive_yellow_alarm      (RX_YELLOW_ALARM),
    .loop_up_code_seen         (LOOP_UP_SEEN),
    .loop_down_code_seen       (LOOP_DOWN_SEEN),
    .receive_unframed_all_ones (RX_UNFRAMED_ALL_ONES),
    .receive_remote_alarm      (RX_REMOTE_ALARM),
    .distant_multiframe_alarm  (DISTANT_MF_ALARM),
    .v5_link_indication        (V5_LINK_INDICATION),
    .signaling_change          (SIGNALING_CHANGE),
    .elastic_store_slip        (ELASTIC_STORE_SLIP),
    .status                    (user_status_b)
  );

  // ****************************************
  // Read decode and group handshake
  // ****************************************
  logic          rd_info;
  logic          own_group_read;
  logic          peer_group_read;
  logic          own_echo;
  logic          rd_ctrl;
  gsb_grp_code_t own_code;
  gsb_grp_code_t active_code;
  logic          member_status;
  logic          drive_group;

  assign rd_info = RD && (ADDR >= GSB_ADDR_INT_STATUS) && (ADDR <= GSB_ADDR_USER_TWO);
  assign rd_ctrl = RD && ((ADDR == GSB_ADDR_ENABLE_LINE) || (ADDR == GSB_ADDR_LINE_ALARM));
  assign own_code = gsb_grp_code_t'(ADDR[1:0] - GSB_ADDR_INT_STATUS[1:0]);
  assign own_group_read  = rd_info && group_report_enable;
  // Own pull lingers on the read line one cycle past the host read;
  // taken as a peer read it would drive our line after the read ends
  assign own_echo        = GROUP_READ_OE;
  // A peer's read reaches us as a low read line, code on the select lines
  assign peer_group_read = !GROUP_READ_IN && !own_echo && group_report_enable;
  assign active_code = own_group_read ? own_code
                     : gsb_grp_code_t'({GROUP_SELECT_B_IN, GROUP_SELECT_A_IN});
  assign drive_group = own_group_read || peer_group_read;

  always_comb begin
    case (active_code)
      GSB_GRP_INT:   member_status = INTERRUPT_PENDING;
      GSB_GRP_SYNC:  member_status = RX_SYNC_LOSS;
      GSB_GRP_USER1: member_status = user_status_a;
      GSB_GRP_USER2: member_status = user_status_b;
      default:       member_status = 1'b0;
    endcase
  end

  // ****************************************
  // Bus line drive
  // ****************************************
  logic [DATA_W-1:0] nxt_ad_out;
  logic [DATA_W-1:0] nxt_ad_oe;
  logic [DATA_W-1:0] ctrl_rdata;

  assign ctrl_rdata = (ADDR == GSB_ADDR_ENABLE_LINE) ? enable_line_ff : line_alarm_ff;

  // One line per member keeps the shared bus free of contention
  for (genvar i = 0; i < DATA_W; i++) begin : g_line
    logic on_line;
    assign on_line       = drive_group && (data_line_select == 3'(i));
    assign nxt_ad_oe[i]  = rd_ctrl || on_line;
    assign nxt_ad_out[i] = rd_ctrl ? ctrl_rdata[i] : (on_line && member_status);
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      AD_OUT <= '0;
      AD_OE  <= '0;
    end else begin
      AD_OUT <= nxt_ad_out;
      AD_OE  <= nxt_ad_oe;
    end
  end

  // ****************************************
  // Open-drain group lines
  // ****************************************
  // Pulled-up lines idle high, so a code bit of zero is a driven low
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      GROUP_SELECT_A_OUT <= 1'b0;
      GROUP_SELECT_A_OE  <= 1'b0;
      GROUP_SELECT_B_OUT <= 1'b0;
      GROUP_SELECT_B_OE  <= 1'b0;
      GROUP_READ_OUT     <= 1'b0;
      GROUP_READ_OE      <= 1'b0;
    end else begin
      // Open-drain value stays low, only the enables move
      GROUP_SELECT_A_OUT <= 1'b0;
      GROUP_SELECT_B_OUT <= 1'b0;
      GROUP_READ_OUT     <= 1'b0;
      GROUP_SELECT_A_OE <= own_group_read && !own_code[0];
      GROUP_SELECT_B_OE <= own_group_read && !own_code[1];
      GROUP_READ_OE     <= own_group_read;
    end
  end
endmodule

// ---- tb/gsb_reporter_sva.sv ----
// Port checker of the grouped status bus reporter
module gsb_reporter_sva
  import gsb_pkg::*;
#(
  parameter int DATA_W = 8
)
(
  // Host port
  input wire logic              CLK,
  input wire logic              RSTN,
  input wire logic [7:0]        ADDR,
  input wire logic [DATA_W-1:0] WDATA,
  input wire logic              WR,
  input wire logic              RD,
  input wire logic [DATA_W-1:0] AD_OUT,
  input wire logic [DATA_W-1:0] AD_OE,
  // Group lines and status
  input wire logic              GROUP_SELECT_A_IN,
  input wire logic              GROUP_SELECT_B_IN,
  input wire logic              GROUP_SELECT_A_OE,
  input wire logic              GROUP_SELECT_B_OE,
  input wire logic              GROUP_READ_IN,
  input wire logic              GROUP_READ_OUT,
  input wire logic              GROUP_READ_OE,
  input wire logic              INTERRUPT_PENDING,
  input wire logic              RX_SYNC_LOSS
);
  logic [3:0] ctl_ff;
  wire        en   = ctl_ff[0];
  wire  [2:0] line = ctl_ff[3:1];
  wire  [7:0] hot  = 8'h01 << line;
  wire  [1:0] code = ADDR[1:0] + 2'h2;
  wire        info = RD && ADDR >= GSB_ADDR_INT_STATUS && ADDR <= GSB_ADDR_USER_TWO;
  wire        peer = !RD && !GROUP_READ_IN && !GROUP_READ_OE && en;
  // Shadow of enable and line; unused bits are never stored
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN)
      ctl_ff <= 4'h0;
    else if (WR && ADDR == GSB_ADDR_ENABLE_LINE)
      ctl_ff <= WDATA[3:0];
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);
  a_reset_quiet: assert property (disable iff (1'b0) !RSTN |-> AD_OE == '0 && !GROUP_READ_OE)
    else $error("drive in reset");
  a_disabled_silent: assert property (info && !en && GROUP_READ_IN |=> AD_OE == '0 && !GROUP_READ_OE)
    else $error("disabled member drove");
  a_info_line: assert property (info && en |=> AD_OE == $past(hot))
    else $error("wrong data line");
  a_read_pull: assert property (info && en |=> GROUP_READ_OE && !GROUP_READ_OUT)
    else $error("group read not signalled");
  a_code_pattern: assert property (info && en |=> {GROUP_SELECT_B_OE, GROUP_SELECT_A_OE} == ~$past(code))
    else $error("wrong select code");
  a_int_value: assert property (info && en && ADDR == GSB_ADDR_INT_STATUS && $past(RD) && $stable(ADDR)
    |=> AD_OUT[$past(line)] == $past(INTERRUPT_PENDING))
    else $error("wrong interrupt bit");
  a_sync_value: assert property (info && en && ADDR == GSB_ADDR_SYNC_STATUS && $past(RD) && $stable(ADDR)
    |=> AD_OUT[$past(line)] == $past(RX_SYNC_LOSS))
    else $error("wrong sync bit");
  a_ctrl_read: assert property (RD && ADDR == GSB_ADDR_ENABLE_LINE |=> AD_OE == '1 && AD_OUT == {4'h0, $past(ctl_ff)})
    else $error("wrong control read");
  a_peer_answer: assert property (peer && {GROUP_SELECT_B_IN, GROUP_SELECT_A_IN} == 2'h1
    |=> AD_OE == $past(hot) && AD_OUT[$past(line)] == $past(RX_SYNC_LOSS))
    else $error("wrong peer answer");
  a_idle_quiet: assert property (!RD && (GROUP_READ_IN || GROUP_READ_OE) |=> AD_OE == '0)
    else $error("drive outside read");
  c_info: cover property (info && en);
  c_peer: cover property (peer);
  c_ctrl: cover property (RD && ADDR == GSB_ADDR_LINE_ALARM);
endmodule

// ---- tb/gsb_peer_model.sv ----
// Peer group member on the shared open-drain group lines
module gsb_peer_model
(
  // Dut pull-down enables
  input  wire logic       dut_a_oe,
  input  wire logic       dut_b_oe,
  input  wire logic       dut_rd_oe,
  // Peer request
  input  wire logic       pull,
  input  wire logic [1:0] code,
  // Resolved levels
  output logic            a_line,
  output logic            b_line,
  output logic            rd_line
);
  timeunit 1ns;
  timeprecision 100ps;
  // Pull-ups win unless some member pulls low, so a released line reads high
  assign rd_line = !(dut_rd_oe || pull);
  assign a_line  = !(dut_a_oe || (pull && !code[0]));
  assign b_line  = !(dut_b_oe || (pull && !code[1]));
endmodule

// ---- tb/gsb_reporter_tb.sv ----
// Self-checking bench of the grouped status bus reporter
`define CHK(nm, e, s) begin n_compared++; if ((s) !== (e)) begin fail_count++; \
  $display("mismatch %s expected %h seen %h", nm, e, s); end end
module gsb_reporter_tb
  import gsb_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic        CLK = 0, RSTN = 1, WR = 0, RD = 0, e1 = 0, pull = 0;
  logic [7:0]  ADDR = 8'h00, WDATA = 8'h00, AD_OUT, AD_OE;
  logic [11:0] st = 12'h000;
  logic [1:0]  pcode = 2'h0;
  logic        sa_oe, sb_oe, rd_oe, sa_out, sb_out, rd_out, sa_in, sb_in, rd_in;
  int          fail_count = 0, n_compared = 0, m1 = 0, m2 = 0;
  gsb_reporter u_dut (.CLK, .RSTN, .ADDR, .WDATA, .WR, .RD, .AD_OUT, .AD_OE,
    .GROUP_SELECT_A_IN(sa_in), .GROUP_SELECT_A_OUT(sa_out), .GROUP_SELECT_A_OE(sa_oe),
    .GROUP_SELECT_B_IN(sb_in), .GROUP_SELECT_B_OUT(sb_out), .GROUP_SELECT_B_OE(sb_oe),
    .GROUP_READ_IN(rd_in), .GROUP_READ_OUT(rd_out), .GROUP_READ_OE(rd_oe),
    .E1_MODE(e1), .INTERRUPT_PENDING(st[0]), .RX_SYNC_LOSS(st[1]), .RX_BLUE_ALARM(st[2]),
    .RX_YELLOW_ALARM(st[3]), .LOOP_UP_SEEN(st[4]), .LOOP_DOWN_SEEN(st[5]),
    .SIGNALING_CHANGE(st[6]), .ELASTIC_STORE_SLIP(st[7]), .RX_UNFRAMED_ALL_ONES(st[8]),
    .RX_REMOTE_ALARM(st[9]), .DISTANT_MF_ALARM(st[10]), .V5_LINK_INDICATION(st[11]));
  gsb_peer_model u_peer (.dut_a_oe(sa_oe), .dut_b_oe(sb_oe), .dut_rd_oe(rd_oe), .pull,
    .code(pcode), .a_line(sa_in), .b_line(sb_in), .rd_line(rd_in));
  // ********
  // Model and bus tasks
  // ********
  function automatic logic stat(int c);
    int s;
    s = (c == 2) ? (m2 & 7) : ((m2 >> 4) & 7);
    if (c < 2)
      return st[c];
    if (s > 5)
      return 1'b0;
    return (s < 4 && e1) ? st[s + 8] : st[s + 2];
  endfunction
  task automatic wr(int a, int d);
    @(posedge CLK) #1;
    WR = 1;
    ADDR = 8'(a);
    WDATA = 8'(d);
    @(posedge CLK) #1;
    WR = 0;
    if (a == 8'hb0)
      m1 = d & 8'h0f;
    if (a == 8'hb1)
      m2 = d & 8'h77;
  endtask
  // Host read, or peer group read when grp is set; a holds the group code then
  task automatic rq(int a, bit grp);
    logic [7:0] oe;
    logic [7:0] out;
    int         c;
    bit         on;
    c = grp ? a : a - 8'hb2;
    on = (m1 & 1) && (grp || (a >= 8'hb2 && a <= 8'hb5));
    oe = (a < 8'hb2 && !grp) ? 8'hff : on ? 8'h01 << (m1 >> 1) : 8'h00;
    @(posedge CLK) #1;
    st = 12'($urandom);
    pcode = 2'(a);
    pull = grp;
    RD = !grp;
    ADDR = 8'(a);
    repeat (2) @(posedge CLK);
    #1;
    out = (a == 8'hb0) ? 8'(m1) : (a == 8'hb1) ? 8'(m2) : {8{stat(c)}};
    `CHK("line enables", oe, AD_OE)
    `CHK("data", out & oe, AD_OUT & oe)
    if (!grp)
      `CHK("group lines", {on, ~2'(c)} & {3{on}}, {rd_oe, sb_oe, sa_oe})
    RD = 0;
    pull = 0;
    @(posedge CLK) #1;
    `CHK("idle enables", 8'h00, AD_OE)
    `CHK("group line levels", 3'h0, {rd_out, sb_out, sa_out})
    repeat (2) @(posedge CLK);
  endtask
  task automatic give_verdict();
    if (fail_count == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // ********
  // Clock, watchdog and scenarios
  // ********
  initial begin
    forever #4 CLK = ~CLK;
  end
  // Whole run needs about 530 cycles, so this is a wide margin
  initial begin
    #100000;
    fail_count++;
    give_verdict();
  end
  initial begin
    void'($urandom(32'h726f));
    // Reset falls after time zero so the asynchronous reset sees an edge
    #1;
    RSTN = 0;
    repeat (20) @(posedge CLK);
    #1;
    RSTN = 1;
    for (int a = 8'hb0; a <= 8'hb6; a++)
      rq(a, 0);
    wr(8'hb1, 8'h77);
    rq(8'hb1, 0);
    // Each pass stands for one member on its own line
    for (int l = 0; l < 8; l++) begin
      wr(8'hb0, 1 | (l << 1));
      rq(8'hb0, 0);
      rq(8'hb2, 0);
      rq(8'hb3, 0);
    end
    for (int s = 0; s < 16; s++) begin
      e1 = s[3];
      wr(8'hb1, (s & 7) | ((~s & 7) << 4));
      wr(8'hb0, 1 | ($urandom & 14));
      rq(8'hb4, 0);
      rq(8'hb5, 0);
    end
    for (int c = 0; c < 4; c++)
      rq(c, 1);
    wr(8'hb0, 8'h0e);
    rq(1, 1);
    rq(8'hb3, 0);
    give_verdict();
  end
endmodule
bind gsb_reporter gsb_reporter_sva #(.DATA_W(DATA_W)) u_sva (.CLK, .RSTN, .ADDR, .WDATA,
  .WR, .RD, .AD_OUT, .AD_OE, .GROUP_SELECT_A_IN, .GROUP_SELECT_B_IN, .GROUP_SELECT_A_OE,
  .GROUP_SELECT_B_OE, .GROUP_READ_IN, .GROUP_READ_OUT, .GROUP_READ_OE, .INTERRUPT_PENDING,
  .RX_SYNC_LOSS);
